// *** design/idp_map.vh ***
`ifndef IDP_MAP_VH
`define IDP_MAP_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define IDP_OFF_CTRL 12'h000
`define IDP_OFF_STAT 12'h004
`define IDP_OFF_DATA 12'h008
`define IDP_OFF_CYLS 12'h00c
`define IDP_OFF_SPT 12'h010
`define IDP_OFF_CAP 12'h014
`define IDP_OFF_MULT 12'h018
`define IDP_OFF_UDMA 12'h01c
`define IDP_OFF_STRW 12'h020
// ----------------------------------------
// Control bits
// ----------------------------------------
`define IDP_CTRL_START 0
`define IDP_CTRL_PCMODE 1
// ----------------------------------------
// Fixed page words
// ----------------------------------------
`define IDP_W_GENCFG 16'h848a
`define IDP_W_HEADS 16'h0010
`define IDP_W_W4 16'h0000
`define IDP_W_W5 16'h0200
`define IDP_W_W20 16'h0002
`define IDP_W_W21 16'h0001
`define IDP_W_W22 16'h0004
`define IDP_W_MAXMUL_HI 8'h80
`define IDP_W_CAPS 16'h0f00
`define IDP_W_PIOTIM 16'h0200
`define IDP_W_VALID 16'h0007
`define IDP_W_MULT_VALID 8'h01
`define IDP_W_MWDMA 16'h0007
`define IDP_W_PIOMODES 16'h0003
`define IDP_W_CYCTIME 16'h0078
`define IDP_W_VER_LO 16'h0020
`define IDP_W_VER_HI 16'h0000
`define IDP_W_CS82 16'h7008
`define IDP_W_CS83 16'h5004
`define IDP_W_CS84 16'h4000
`define IDP_W_CS85 16'h7008
`define IDP_W_CS86 16'h1004
`define IDP_W_CS87 16'h4000
`define IDP_W_UDMA_LO 8'h1f
`define IDP_W_RESET_RES 16'h404f
`define IDP_PAGE_LAST 8'hff
// ----------------------------------------
// Reset values of card-specific words
// ----------------------------------------
`define IDP_RST_CYLS 16'h0000
`define IDP_RST_SPT 8'h00
`define IDP_RST_CAP 32'h00000000
`define IDP_RST_MULT 8'h01
`endif

// *** design/idp_str_mem.v ***
`timescale 1ns/1ns
// ----------------------------------------
// String word store: 34 words of ASCII text
// ----------------------------------------
module idp_str_mem (
  // Clock
  input wire pclk,
  // Write port
  input wire wr_en,
  input wire [5:0] wr_addr,
  input wire [15:0] wr_data,
  // Read port, data registered
  input wire [5:0] rd_addr,
  output reg [15:0] rd_data
);
  reg [15:0] mem [0:33];

  always @(posedge pclk) begin
    if (wr_en && wr_addr < 6'd34) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= (rd_addr < 6'd34) ? mem[rd_addr] : 16'h0000;
  end
endmodule

// *** design/idp_page.v ***
`timescale 1ns/1ns
`include "idp_map.vh"
module idp_page (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_FETCH = 3'b010;
  localparam ST_READY = 3'b100;

  reg [2:0] state;
  reg [7:0] word_idx;
  reg [15:0] data_word;
  reg pc_mode;
  reg [15:0] cyls;
  reg [7:0] spt;
  reg [31:0] capacity;
  reg [7:0] max_mult;
  reg [7:0] cur_mult;
  reg [5:0] udma_sel;
  reg [5:0] str_wr_addr;
  reg wait_rd;
  wire [15:0] str_rd;
  wire acc;
  wire wr_acc;
  wire rd_data_acc;
  wire str_wr;
  reg [15:0] fixed_word;
  reg [5:0] str_rd_addr;
  reg is_str;

  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign rd_data_acc = acc && !pwrite && paddr == `IDP_OFF_DATA && state == ST_READY;
  assign str_wr = wr_acc && paddr == `IDP_OFF_STRW;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [5:0] onehot_sel;
    input [2:0] mode;
    begin
      onehot_sel = (mode < 3'd6) ? (6'h01 << mode) : 6'h00;
    end
  endfunction

  function is_str_word;
    input [7:0] w;
    begin
      is_str_word = (w >= 8'd10 && w <= 8'd19) || (w >= 8'd23 && w <= 8'd46);
    end
  endfunction

  // ----------------------------------------
  // Text store address: serial 0-9, fw and model 10-33
  // ----------------------------------------
  always @* begin
    is_str = is_str_word(word_idx);
    if (word_idx >= 8'd10 && word_idx <= 8'd19) begin
      str_rd_addr = word_idx[5:0] - 6'd10;
    end else if (word_idx >= 8'd23 && word_idx <= 8'd46) begin
      str_rd_addr = word_idx[5:0] - 6'd13;
    end else begin
      str_rd_addr = 6'd0;
    end
  end

  idp_str_mem u_str (
    .pclk(pclk),
    .wr_en(str_wr),
    .wr_addr(pwdata[21:16]),
    .wr_data(pwdata[15:0]),
    .rd_addr(str_rd_addr),
    .rd_data(str_rd)
  );

  // ----------------------------------------
  // Page word table
  // ----------------------------------------
  always @* begin
    case (word_idx)
      8'd0: fixed_word = `IDP_W_GENCFG;
      8'd1: fixed_word = cyls;
      8'd3: fixed_word = `IDP_W_HEADS;
      8'd4: fixed_word = `IDP_W_W4;
      8'd5: fixed_word = `IDP_W_W5;
      8'd6: fixed_word = {8'h00, spt};
      8'd7: fixed_word = capacity[31:16];
      8'd8: fixed_word = capacity[15:0];
      8'd20: fixed_word = `IDP_W_W20;
      8'd21: fixed_word = `IDP_W_W21;
      8'd22: fixed_word = `IDP_W_W22;
      8'd47: fixed_word = {`IDP_W_MAXMUL_HI, max_mult};
      8'd49: fixed_word = `IDP_W_CAPS;
      8'd51: fixed_word = `IDP_W_PIOTIM;
      8'd53: fixed_word = `IDP_W_VALID;
      8'd54: fixed_word = cyls;
      8'd55: fixed_word = `IDP_W_HEADS;
      8'd56: fixed_word = {8'h00, spt};
      8'd57: fixed_word = capacity[15:0];
      8'd58: fixed_word = capacity[31:16];
      8'd59: fixed_word = {`IDP_W_MULT_VALID, cur_mult};
      8'd60: fixed_word = capacity[15:0];
      8'd61: fixed_word = capacity[31:16];
      8'd63: fixed_word = `IDP_W_MWDMA;
      8'd64: fixed_word = `IDP_W_PIOMODES;
      8'd65: fixed_word = pc_mode ? 16'h0000 : `IDP_W_CYCTIME;
      8'd66: fixed_word = pc_mode ? 16'h0000 : `IDP_W_CYCTIME;
      8'd67: fixed_word = `IDP_W_CYCTIME;
      8'd68: fixed_word = `IDP_W_CYCTIME;
      8'd80: fixed_word = `IDP_W_VER_LO;
      8'd81: fixed_word = `IDP_W_VER_HI;
      8'd82: fixed_word = `IDP_W_CS82;
      8'd83: fixed_word = `IDP_W_CS83;
      8'd84: fixed_word = `IDP_W_CS84;
      8'd85: fixed_word = `IDP_W_CS85;
      8'd86: fixed_word = `IDP_W_CS86;
      8'd87: fixed_word = `IDP_W_CS87;
      8'd88: fixed_word = {2'b00, udma_sel, `IDP_W_UDMA_LO};
      8'd93: fixed_word = `IDP_W_RESET_RES;
      default: fixed_word = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  // The store read is registered, so each word spends two cycles in ST_FETCH, the first waiting on the store.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      word_idx <= 8'h00;
      data_word <= 16'h0000;
      wait_rd <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (wr_acc && paddr == `IDP_OFF_CTRL && pwdata[`IDP_CTRL_START]) begin
            word_idx <= 8'h00;
            state <= ST_FETCH;
            wait_rd <= 1'b1;
          end
        end
        ST_FETCH: begin
          if (wait_rd) begin
            wait_rd <= 1'b0;
          end else begin
            data_word <= is_str ? str_rd : fixed_word;
            state <= ST_READY;
          end
        end
        ST_READY: begin
          if (rd_data_acc) begin
            if (word_idx == `IDP_PAGE_LAST) begin
              state <= ST_IDLE;
            end else begin
              word_idx <= word_idx + 8'd1;
              state <= ST_FETCH;
              wait_rd <= 1'b1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_mode <= 1'b0;
      cyls <= `IDP_RST_CYLS;
      spt <= `IDP_RST_SPT;
      capacity <= `IDP_RST_CAP;
      max_mult <= `IDP_RST_MULT;
      cur_mult <= `IDP_RST_MULT;
      udma_sel <= 6'h00;
      str_wr_addr <= 6'd0;
    end else if (wr_acc) begin
      case (paddr)
        `IDP_OFF_CTRL: pc_mode <= pwdata[`IDP_CTRL_PCMODE];
        `IDP_OFF_CYLS: cyls <= pwdata[15:0];
        `IDP_OFF_SPT: spt <= pwdata[7:0];
        `IDP_OFF_CAP: capacity <= pwdata;
        `IDP_OFF_MULT: begin
          // Zero maximum is reserved, so it is kept at its previous value
          if (pwdata[7:0] != 8'h00) begin
            max_mult <= pwdata[7:0];
          end
          cur_mult <= pwdata[15:8];
        end
        `IDP_OFF_UDMA: udma_sel <= pwdata[3] ? onehot_sel(pwdata[2:0]) : 6'h00;
        `IDP_OFF_STRW: str_wr_addr <= pwdata[21:16];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // APB answer: no wait state, ready in the first access cycle
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= 1'b0;
        case (paddr)
          `IDP_OFF_CTRL: prdata <= {30'h0, pc_mode, 1'b0};
          `IDP_OFF_STAT: prdata <= {15'h0, state == ST_READY, word_idx, 5'h0, state};
          `IDP_OFF_DATA: prdata <= {16'h0, state == ST_READY ? data_word : 16'h0000};
          `IDP_OFF_CYLS: prdata <= {16'h0, cyls};
          `IDP_OFF_SPT: prdata <= {24'h0, spt};
          `IDP_OFF_CAP: prdata <= capacity;
          `IDP_OFF_MULT: prdata <= {16'h0, cur_mult, max_mult};
          `IDP_OFF_UDMA: prdata <= {26'h0, udma_sel};
          `IDP_OFF_STRW: prdata <= {10'h0, str_wr_addr, 16'h0};
          default: begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end else begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule

// *** verification/idp_chk_checker.sv ***
`timescale 1ns/1ns
// ----------------
// APB port checker
// ----------------
module idp_chk (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // APB
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rd(a);
    pready && !pwrite && paddr == a;
  endsequence
  // Misaligned offsets count as unmapped too
  wire unm = paddr > 12'h020 || paddr[1:0] != 2'b00;
  AST_ONE_WAIT: assert property (s_setup |=> pready && penable)
    else $error("no answer after one wait");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_RDY_ACCESS: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside access");
  AST_ERR_UNMAP: assert property (pready && unm |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped not refused");
  AST_ERR_MAP: assert property (pready && !unm |-> !pslverr)
    else $error("mapped refused");
  AST_DATA_UPPER: assert property (s_rd(12'h008) |-> prdata[31:16] == 16'h0000)
    else $error("page word upper half set");
  AST_STAT_STATE: assert property (s_rd(12'h004) |-> $onehot(prdata[2:0]))
    else $error("state not one-hot");
  AST_RD_HOLD: assert property (pready ##1 !psel |-> $stable(prdata))
    else $error("read data moved");
endmodule
bind idp_page idp_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// *** verification/idp_host.sv ***
`timescale 1ns/1ns
// ----------------------
// Host APB master model
// ----------------------
module idp_host (
  // Clock
  input logic pclk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Answer is taken at the rising edge that sees pready high; the bus is released at that edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic to);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    to = 1'b1;
    for (n = 0; n < 20 && to; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        to = 1'b0;
        q = prdata;
        e = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ns
`define CHK(n, x, g) begin checks_done++; if ((g) !== (x)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, x, g); end end
// -----------------
// Page bench
// -----------------
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, to, pc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, cap;
  logic [15:0] cyl;
  logic [7:0] spt, mx, cur;
  logic [5:0] usel;
  logic [3:0] ud [3] = '{4'hc, 4'h8, 4'hf};
  logic [15:0] mw [3] = '{16'h1020, 16'h0800, 16'h40ff};
  int fail_count, checks_done, r, i, k, t, n;
  idp_page i_idp_page (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  idp_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task complete_run;
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    host.xfer(w, a, d, q, e, to);
    if (to) begin
      fail_count++;
      complete_run();
    end
  endtask
  function logic [15:0] tv(input int j);
    tv = {j[7:0] + 8'h20, j[7:0] + 8'h30};
  endfunction
  function logic [15:0] ew(input int j);
    case (j)
      0: ew = 16'h848a;
      1, 54: ew = cyl;
      3, 55: ew = 16'h0010;
      5, 51: ew = 16'h0200;
      6, 56: ew = {8'h00, spt};
      7, 58, 61: ew = cap[31:16];
      8, 57, 60: ew = cap[15:0];
      20: ew = 16'h0002;
      21: ew = 16'h0001;
      22: ew = 16'h0004;
      47: ew = {8'h80, mx};
      49: ew = 16'h0f00;
      53, 63: ew = 16'h0007;
      59: ew = {8'h01, cur};
      64: ew = 16'h0003;
      65, 66: ew = pc ? 16'h0000 : 16'h0078;
      67, 68: ew = 16'h0078;
      80: ew = 16'h0020;
      82, 85: ew = 16'h7008;
      83: ew = 16'h5004;
      84, 87: ew = 16'h4000;
      86: ew = 16'h1004;
      88: ew = {2'b00, usel, 8'h1f};
      93: ew = 16'h404f;
      default: ew = (j >= 10 && j <= 46) ? tv(j) : 16'h0000;
    endcase
  endfunction
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, 12'h018, 32'h0); `CHK("mult", 32'h00000101, q)
    acc(1'b0, 12'h004, 32'h0); `CHK("stat", 32'h00000001, q)
    acc(1'b1, 12'h004, 32'h7); `CHK("staterr", 1'b0, e)
    acc(1'b0, 12'h040, 32'h0); `CHK("unmap", 33'h100000000, {e, q})
    acc(1'b1, 12'h03c, 32'h1); `CHK("unmapw", 1'b1, e)
    cyl = 16'hc1a5;
    spt = 8'h3f;
    cap = 32'h0007a1c3;
    mx = 8'h01;
    acc(1'b1, 12'h00c, {16'h0000, cyl});
    acc(1'b1, 12'h010, {24'h000000, spt});
    acc(1'b1, 12'h014, cap);
    // Text store has no reset value, so it is filled before any page run
    for (k = 10; k < 47; k++) begin
      t = k < 20 ? k - 10 : k - 13;
      if (k < 20 || k > 22) acc(1'b1, 12'h020, {10'h000, t[5:0], tv(k)});
    end
    for (r = 0; r < 3; r++) begin
      pc = r[0];
      acc(1'b1, 12'h018, {16'h0000, mw[r]});
      if (mw[r][7:0] != 8'h00) mx = mw[r][7:0];
      cur = mw[r][15:8];
      acc(1'b1, 12'h01c, {28'h0000000, ud[r]});
      usel = (ud[r][3] && ud[r][2:0] <= 3'h5) ? 6'h01 << ud[r][2:0] : 6'h00;
      acc(1'b1, 12'h000, {30'h0, pc, 1'b1});
      for (i = 0; i < 256; i++) begin
        n = 0;
        q = 32'h0;
        while (q[16] !== 1'b1) begin
          if (++n > 50) begin
            fail_count++;
            complete_run();
          end
          acc(1'b0, 12'h004, 32'h0);
        end
        `CHK("idx", i[7:0], q[15:8])
        acc(1'b0, 12'h008, 32'h0);
        `CHK("word", {16'h0000, ew(i)}, q)
      end
      acc(1'b0, 12'h004, 32'h0); `CHK("idle", 32'h0000ff01, q)
    end
    complete_run();
  end
endmodule
